// ===== design/laser_bank_defines.svh
`ifndef LASER_BANK_DEFINES_SVH
`define LASER_BANK_DEFINES_SVH


// Command codes
`define CODE_MEASURED_RESULT   8'h00
`define CODE_SOURCE_SETTING    8'h01
`define CODE_MODULATION_SETTING 8'h02
`define CODE_POWER_LIMIT       8'h03

// Field layout
`define SETTING_MSB            9
`define LIMIT_MSB              6
`define LIMIT_SHIFT            3

// Reset values
`define RESET_SETTING          10'h000
`define RESET_RESULT           10'h000
`define RESET_LIMIT            7'h00
`define RESET_READ_DATA        16'h0000

`endif

// ===== design/laser_bank_pkg.sv
package laser_bank_pkg;

    // One command from the serial front end
    typedef struct packed {
        logic [7:0]  code;
        logic        write;
        logic        read;
        logic [15:0] wdata;
    } reg_cmd_t;

    // Which converter channel a sample came from
    typedef enum logic [1:0] {
        SAMPLE_SOURCE  = 2'h1,
        SAMPLE_MONITOR = 2'h2
    } sample_kind_t;

    // One converter result
    typedef struct packed {
        logic         valid;
        sample_kind_t kind;
        logic [9:0]   code;
    } sample_t;

endpackage : laser_bank_pkg

// ===== design/laser_current_register_bank.sv
`timescale 1ns/1ps
`include "laser_bank_defines.svh"

module laser_current_register_bank #(
    parameter int CODE_W = 10
) (
    // Clock and reset
    input  wire logic                     i_clock,
    input  wire logic                     i_rst,

    // Command port from the serial front end
    input  wire laser_bank_pkg::reg_cmd_t i_cmd,
    output logic [15:0]                   o_read_data,
    output logic                          o_read_valid,
    output logic                          o_write_refused,

    // Mode settings
    input  wire logic                     i_power_loop_enable,
    input  wire logic                     i_power_ctrl_enable,

    // Converter results
    input  wire laser_bank_pkg::sample_t  i_sample,

    // Values driven to the current sources, the captured power limit, and the captured measured result
    output logic [CODE_W-1:0]             o_source_current_value,
    output logic [CODE_W-1:0]             o_modulation_current_value,
    output logic [`LIMIT_MSB:0]           o_power_limit_value,
    output logic [CODE_W-1:0]             o_measured_result
);

    // Elaboration check
    if (CODE_W != 10) begin : g_width_check
        $error("CODE_W must be 10 to match the register fields");
    end

    // Setting registers
    logic [CODE_W-1:0]     source_q;
    logic [CODE_W-1:0]     source_d;
    logic [CODE_W-1:0]     modulation_q;
    logic [CODE_W-1:0]     modulation_d;

    // Read return and write refusal
    logic [15:0]           read_data_q;
    logic [15:0]           read_data_d;
    logic                  read_valid_q;
    logic                  read_valid_d;
    logic                  refused_q;
    logic                  refused_d;

    // Decode
    logic                  hit_source;
    logic                  hit_modulation;
    logic                  write_open;
    logic                  write_taken;

    // Captured converter values
    logic [CODE_W-1:0]     result_value;
    logic [`LIMIT_MSB:0]   limit_value;

    sample_capture #(
        .CODE_W              (CODE_W)
    ) u_capture (
        .i_clock             (i_clock),
        .i_rst               (i_rst),
        .i_sample            (i_sample),
        .i_power_loop_enable (i_power_loop_enable),
        .o_result            (result_value),
        .o_limit             (limit_value)
    );

    // Write path
    always_comb begin
        hit_source     = (i_cmd.code == `CODE_SOURCE_SETTING);
        hit_modulation = (i_cmd.code == `CODE_MODULATION_SETTING);
        write_open     = !i_power_ctrl_enable;
        write_taken    = i_cmd.write && write_open
                         && (hit_source || hit_modulation);
        source_d       = source_q;
        modulation_d   = modulation_q;
        if (write_taken && hit_source) begin
            source_d = i_cmd.wdata[`SETTING_MSB:0];
        end
        if (write_taken && hit_modulation) begin
            modulation_d = i_cmd.wdata[`SETTING_MSB:0];
        end
        refused_d = i_cmd.write && !write_taken;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            source_q     <= `RESET_SETTING;
            modulation_q <= `RESET_SETTING;
            refused_q    <= 1'b0;
        end else begin
            source_q     <= source_d;
            modulation_q <= modulation_d;
            refused_q    <= refused_d;
        end
    end

    // Read path
    always_comb begin
        read_valid_d = i_cmd.read;
        read_data_d  = read_data_q;
        if (i_cmd.read) begin
            case (i_cmd.code)
                `CODE_MEASURED_RESULT: begin
                    read_data_d = {6'h00, result_value};
                end
                `CODE_SOURCE_SETTING: begin
                    read_data_d = {6'h00, source_q};
                end
                `CODE_MODULATION_SETTING: begin
                    read_data_d = {6'h00, modulation_q};
                end
                `CODE_POWER_LIMIT: begin
                    read_data_d = {9'h000, limit_value};
                end
                default: begin
                    read_data_d = `RESET_READ_DATA;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            read_data_q  <= `RESET_READ_DATA;
            read_valid_q <= 1'b0;
        end else begin
            read_data_q  <= read_data_d;
            read_valid_q <= read_valid_d;
        end
    end

    // Outputs
    assign o_read_data                = read_data_q;
    assign o_read_valid               = read_valid_q;
    assign o_write_refused            = refused_q;
    assign o_source_current_value     = source_q;
    assign o_modulation_current_value = modulation_q;
    assign o_power_limit_value        = limit_value;
    assign o_measured_result          = result_value;

    // Checks

    reset_values_a: assert property (
        @(posedge i_clock)
        i_rst |=> (o_measured_result == 10'h000) && (o_source_current_value == 10'h000)
                  && (o_modulation_current_value == 10'h000)
                  && (o_power_limit_value == 7'h00)
    ) else $error("Bank not cleared by reset");

    source_sample_load_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_sample.valid && !i_power_loop_enable
         && i_sample.kind == laser_bank_pkg::SAMPLE_SOURCE)
        |=> o_measured_result == $past(i_sample.code)
    ) else $error("Source sample not loaded in constant current mode");

    monitor_sample_load_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_sample.valid && i_power_loop_enable
         && i_sample.kind == laser_bank_pkg::SAMPLE_MONITOR)
        |=> o_measured_result == $past(i_sample.code)
    ) else $error("Monitor sample not loaded in power control mode");

    source_write_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.write && !i_power_ctrl_enable && i_cmd.code == 8'h01)
        |=> o_source_current_value == $past(i_cmd.wdata[9:0])
    ) else $error("Source setting write lost");

    modulation_write_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.write && !i_power_ctrl_enable && i_cmd.code == 8'h02)
        |=> o_modulation_current_value == $past(i_cmd.wdata[9:0])
    ) else $error("Modulation setting write lost");

    locked_write_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.write && i_power_ctrl_enable)
        |=> $stable(o_source_current_value) && $stable(o_modulation_current_value)
            && o_write_refused
    ) else $error("Setting changed while controller enabled");

    setting_read_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.read && i_cmd.code == 8'h01)
        |=> o_read_valid && o_read_data == {6'h00, $past(o_source_current_value)}
    ) else $error("Source setting read wrong");

    limit_read_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.read && i_cmd.code == 8'h03)
        |=> o_read_data == {9'h000, $past(o_power_limit_value)}
    ) else $error("Power limit read wrong");

    limit_track_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_sample.valid && i_power_loop_enable
         && i_sample.kind == laser_bank_pkg::SAMPLE_MONITOR)
        |=> o_power_limit_value == $past(i_sample.code[9:3])
    ) else $error("Power limit not following monitor sample");

    reserved_zero_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        o_read_valid |-> o_read_data[15:10] == 6'h00
    ) else $error("Reserved bits read nonzero");

    // Handshake, hold and decode checks

    reset_outputs_a: assert property (
        @(posedge i_clock)
        i_rst |=> !o_read_valid && !o_write_refused
                  && (o_read_data == 16'h0000)
    ) else $error("Command outputs not cleared by reset");

    read_pulse_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        i_cmd.read
        |=> o_read_valid
    ) else $error("Read not answered one cycle later");

    read_idle_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !i_cmd.read
        |=> !o_read_valid && $stable(o_read_data)
    ) else $error("Read answer without a read");

    refused_idle_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !i_cmd.write
        |=> !o_write_refused
    ) else $error("Refusal without a write");

    open_write_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.write && !i_power_ctrl_enable
         && (i_cmd.code == 8'h01 || i_cmd.code == 8'h02))
        |=> !o_write_refused
    ) else $error("Open setting write refused");

    readonly_write_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.write && (i_cmd.code == 8'h00 || i_cmd.code == 8'h03))
        |=> o_write_refused && $stable(o_source_current_value)
            && $stable(o_modulation_current_value)
    ) else $error("Write to read-only register taken");

    modulation_read_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.read && i_cmd.code == 8'h02)
        |=> o_read_valid
            && o_read_data == {6'h00, $past(o_modulation_current_value)}
    ) else $error("Modulation setting read wrong");

    result_read_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.read && i_cmd.code == 8'h00)
        |=> o_read_valid
            && o_read_data == {6'h00, $past(o_measured_result)}
    ) else $error("Measured result read wrong");

    limit_reserved_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.read && i_cmd.code == 8'h03)
        |=> o_read_valid && (o_read_data[15:7] == 9'h000)
    ) else $error("Power limit reserved bits nonzero");

    unmapped_read_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_cmd.read && i_cmd.code > 8'h03)
        |=> o_read_valid && (o_read_data == 16'h0000)
    ) else $error("Unmapped code read nonzero");

    source_hold_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !(i_cmd.write && !i_power_ctrl_enable && i_cmd.code == 8'h01)
        |=> $stable(o_source_current_value)
    ) else $error("Source setting changed without a write");

    modulation_hold_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !(i_cmd.write && !i_power_ctrl_enable && i_cmd.code == 8'h02)
        |=> $stable(o_modulation_current_value)
    ) else $error("Modulation setting changed without a write");

    result_hold_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !(i_sample.valid
          && ((!i_power_loop_enable && i_sample.kind == laser_bank_pkg::SAMPLE_SOURCE)
              || (i_power_loop_enable && i_sample.kind == laser_bank_pkg::SAMPLE_MONITOR)))
        |=> $stable(o_measured_result)
    ) else $error("Result changed without a matching sample");

    limit_hold_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_power_loop_enable
         && !(i_sample.valid && i_sample.kind == laser_bank_pkg::SAMPLE_MONITOR))
        |=> $stable(o_power_limit_value)
    ) else $error("Power limit changed without a monitor sample");

endmodule : laser_current_register_bank

// ===== design/sample_capture.sv
`timescale 1ns/1ps
`include "laser_bank_defines.svh"

module sample_capture #(
    parameter int CODE_W = 10
) (
    // Clock and reset
    input  wire logic                     i_clock,
    input  wire logic                     i_rst,
    // Converter and mode
    input  wire laser_bank_pkg::sample_t  i_sample,
    input  wire logic                     i_power_loop_enable,
    // Captured values
    output logic [CODE_W-1:0]             o_result,
    output logic [`LIMIT_MSB:0]           o_limit
);

    // Elaboration check
    if (CODE_W != 10) begin : g_width_check
        $error("CODE_W must be 10 to match the converter code");
    end

    logic [CODE_W-1:0]     result_q;
    logic [CODE_W-1:0]     result_d;
    logic [`LIMIT_MSB:0]   limit_q;
    logic [`LIMIT_MSB:0]   limit_d;
    logic                  take_source;
    logic                  take_monitor;

    always_comb begin
        take_source  = i_sample.valid && !i_power_loop_enable
                       && (i_sample.kind == laser_bank_pkg::SAMPLE_SOURCE);
        take_monitor = i_sample.valid && i_power_loop_enable
                       && (i_sample.kind == laser_bank_pkg::SAMPLE_MONITOR);
        result_d = result_q;
        limit_d  = limit_q;
        if (take_source || take_monitor) begin
            result_d = i_sample.code;
        end
        if (take_monitor) begin
            limit_d = 7'(i_sample.code >> `LIMIT_SHIFT);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            result_q <= `RESET_RESULT;
            limit_q  <= `RESET_LIMIT;
        end else begin
            result_q <= result_d;
            limit_q  <= limit_d; // Held in constant current mode
        end
    end

    assign o_result = result_q;
    assign o_limit  = limit_q;

endmodule : sample_capture

// ===== verification/host_model.sv
`timescale 1ns/1ps

module host_model (
    // Clock
    input  wire logic                 i_clock,
    // Command to the register bank
    output laser_bank_pkg::reg_cmd_t  o_cmd
);
    initial begin
        o_cmd = '0;
    end

    // One command held over one edge; returns just after it is taken
    // Settings are written with the lock low except where a refusal is meant
    task automatic send(input logic [7:0] code, input logic wr, input logic rd,
                        input logic [15:0] wdata);
        @(posedge i_clock);
        #1;
        o_cmd = '{code, wr, rd, wdata};
        @(posedge i_clock);
        #1;
        o_cmd = '{8'h00, 1'b0, 1'b0, ~wdata};
    endtask : send
endmodule : host_model

// ===== verification/tb.sv
`timescale 1ns/1ps

module tb;
    typedef struct {
        logic [7:0]  code;
        logic [15:0] wdata;
        logic        lock;
        logic        loop;
        logic        refused;
        logic [15:0] rdata;
    } row_t;

    logic                     i_clock;
    logic                     i_rst;
    laser_bank_pkg::reg_cmd_t i_cmd;
    logic                     i_power_loop_enable;
    logic                     i_power_ctrl_enable;
    laser_bank_pkg::sample_t  i_sample;
    logic [15:0]              o_read_data;
    logic                     o_read_valid;
    logic                     o_write_refused;
    logic [9:0]               o_source_current_value;
    logic [9:0]               o_modulation_current_value;
    logic [6:0]               o_power_limit_value;
    logic [9:0]               o_measured_result;
    int                       errors = 0;
    int                       n_checks = 0;
    int                       cycles = 0;

    // Write, refusal expected, then read back
    row_t rows [8] = '{
        '{8'h01, 16'hFFFF, 1'b0, 1'b0, 1'b0, 16'h03FF},
        '{8'h02, 16'h0155, 1'b0, 1'b0, 1'b0, 16'h0155},
        '{8'h01, 16'h0000, 1'b1, 1'b0, 1'b1, 16'h03FF},
        '{8'h02, 16'h02AA, 1'b1, 1'b0, 1'b1, 16'h0155},
        '{8'h03, 16'h007F, 1'b0, 1'b1, 1'b1, 16'h0000},
        '{8'h00, 16'h0123, 1'b0, 1'b0, 1'b1, 16'h0000},
        '{8'h02, 16'h8000, 1'b0, 1'b0, 1'b0, 16'h0000},
        '{8'h07, 16'h0001, 1'b0, 1'b0, 1'b1, 16'h0000}
    };

    host_model u_host (
        .i_clock (i_clock),
        .o_cmd   (i_cmd)
    );

    laser_current_register_bank #(.CODE_W(10)) u_laser_current_register_bank (
        .i_clock                    (i_clock),
        .i_rst                      (i_rst),
        .i_cmd                      (i_cmd),
        .o_read_data                (o_read_data),
        .o_read_valid               (o_read_valid),
        .o_write_refused            (o_write_refused),
        .i_power_loop_enable        (i_power_loop_enable),
        .i_power_ctrl_enable        (i_power_ctrl_enable),
        .i_sample                   (i_sample),
        .o_source_current_value     (o_source_current_value),
        .o_modulation_current_value (o_modulation_current_value),
        .o_power_limit_value        (o_power_limit_value),
        .o_measured_result          (o_measured_result)
    );

    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        u_host.send(code, 1'b0, 1'b1, 16'h0000);
        check("read_valid", {15'h0000, o_read_valid}, 16'h0001);
        check("read_data", o_read_data, exp);
    endtask : rd

    task automatic sample(input laser_bank_pkg::sample_kind_t kind, input logic [9:0] code);
        @(posedge i_clock);
        #1;
        i_sample = '{1'b1, kind, code};
        @(posedge i_clock);
        #1;
        i_sample = '{1'b0, laser_bank_pkg::SAMPLE_MONITOR, ~code};
    endtask : sample

    task automatic zero_check;
        check("result", {6'h00, o_measured_result}, 16'h0000);
        check("source", {6'h00, o_source_current_value}, 16'h0000);
        check("modulation", {6'h00, o_modulation_current_value}, 16'h0000);
        check("limit", {9'h000, o_power_limit_value}, 16'h0000);
    endtask : zero_check

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        i_rst = 1'b1;
        i_power_loop_enable = 1'b0;
        i_power_ctrl_enable = 1'b0;
        i_sample = '{1'b0, laser_bank_pkg::SAMPLE_SOURCE, 10'h000};
        repeat (3) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        zero_check();
        foreach (rows[i]) begin
            i_power_ctrl_enable = rows[i].lock;
            i_power_loop_enable = rows[i].loop;
            u_host.send(rows[i].code, 1'b1, 1'b0, rows[i].wdata);
            check("refused", {15'h0000, o_write_refused}, {15'h0000, rows[i].refused});
            rd(rows[i].code, rows[i].rdata);
        end
        // Converter samples in both modes
        i_power_loop_enable = 1'b0;
        sample(laser_bank_pkg::SAMPLE_SOURCE, 10'h2A5);
        check("result", {6'h00, o_measured_result}, 16'h02A5);
        sample(laser_bank_pkg::SAMPLE_MONITOR, 10'h111);
        check("result", {6'h00, o_measured_result}, 16'h02A5);
        i_power_loop_enable = 1'b1;
        sample(laser_bank_pkg::SAMPLE_MONITOR, 10'h3F8);
        check("result", {6'h00, o_measured_result}, 16'h03F8);
        check("limit", {9'h000, o_power_limit_value}, 16'h007F);
        rd(8'h03, 16'h007F);
        sample(laser_bank_pkg::SAMPLE_SOURCE, 10'h0AA);
        check("result", {6'h00, o_measured_result}, 16'h03F8);
        sample(laser_bank_pkg::SAMPLE_MONITOR, 10'h00F);
        check("limit", {9'h000, o_power_limit_value}, 16'h0001);
        rd(8'h00, 16'h000F);
        // Read and write together: old value comes back
        i_power_loop_enable = 1'b0;
        u_host.send(8'h01, 1'b1, 1'b1, 16'h0010);
        check("read_data", o_read_data, 16'h03FF);
        check("source", {6'h00, o_source_current_value}, 16'h0010);
        // Reset in mid-run
        i_rst = 1'b1;
        @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        zero_check();
        rd(8'h01, 16'h0000);
        print_verdict();
    end
endmodule : tb
